//--- common/arct_params.svh
`ifndef ARCT_PARAMS_SVH
`define ARCT_PARAMS_SVH

// register byte offsets on the apb bus
`define ARCT_OFF_CTRL     12'h000
`define ARCT_OFF_RLD_LO   12'h004
`define ARCT_OFF_RLD_HI   12'h008
`define ARCT_OFF_CNT_LO   12'h00c
`define ARCT_OFF_CNT_HI   12'h010
`define ARCT_OFF_CLKSEL   12'h014
`define ARCT_OFF_MASK     12'h018
`define ARCT_OFF_STATUS   12'h01c

// timer_control field positions
`define ARCT_CTRL_HFLAG   7
`define ARCT_CTRL_LFLAG   6
`define ARCT_CTRL_LEN     5
`define ARCT_CTRL_CEN     4
`define ARCT_CTRL_SPLIT   3
`define ARCT_CTRL_RUN     2
`define ARCT_CTRL_EXT_HI  1
`define ARCT_CTRL_EXT_LO  0

// clock_select_reg field positions
`define ARCT_CLK_LSYS     0
`define ARCT_CLK_HSYS     1

// status and mask field positions
`define ARCT_ST_HIGH      0
`define ARCT_ST_LOW       1

// reset values
`define ARCT_RST_BYTE     8'h00

// prescaler ratios
`define ARCT_SYS_DIV      12
`define ARCT_RTC_DIV      8

`endif

//--- common/arct_pkg.sv
package arct_pkg;

  // external clock select codes, in field order
  typedef enum logic [1:0] {
    ARCT_EXT_SYS12,
    ARCT_EXT_RTC8,
    ARCT_EXT_RSVD,
    ARCT_EXT_CMP0
  } arct_ext_t;

  // one byte of register data
  typedef logic [7:0] arct_byte_t;

endpackage

//--- common/arct_tick_if.sv
`timescale 1ns/1ns
// one-cycle count and capture strobes between prescaler and timer
interface arct_tick_if;
  logic tickSys12;  // system clock / 12
  logic tickRtc8;   // every eighth rtc rising edge
  logic tickCmp0;   // comparator 0 rising edge
  modport src (output tickSys12, output tickRtc8, output tickCmp0);
  modport snk (input tickSys12, input tickRtc8, input tickCmp0);
endinterface

//--- src/arct_tick_gen.sv
`timescale 1ns/1ns
`include "arct_params.svh"
module arct_tick_gen #(
  parameter int SYS_DIV = `ARCT_SYS_DIV,
  parameter int RTC_DIV = `ARCT_RTC_DIV
) (
  // clock and reset
  input  wire logic    sys_clk,
  input  wire logic    rst,
  // asynchronous pins
  input  wire logic    rtcClk,
  input  wire logic    cmp0Out,
  // strobes out
  arct_tick_if.src     ticks
);
  localparam int SW = $clog2(SYS_DIV);
  localparam int RW = $clog2(RTC_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [RW-1:0] RTC_LAST = RW'(RTC_DIV - 1);

  // dividers below two would never produce a slow strobe
  if (SYS_DIV < 2 || RTC_DIV < 2) begin : g_bad_div
    $error("arct_tick_gen: dividers must be at least 2");
  end

  logic [2:0]    rtcSync;     // three-stage rtc synchroniser
  logic [2:0]    cmpSync;     // three-stage comparator synchroniser
  logic          rtcStable;   // debounced rtc level
  logic          cmpStable;   // debounced comparator level
  logic [SW-1:0] sysCnt;      // system clock prescaler
  logic [RW-1:0] rtcCnt;      // rtc edge prescaler
  logic          next_rtcStable;
  logic          next_cmpStable;
  logic [SW-1:0] next_sysCnt;
  logic [RW-1:0] next_rtcCnt;
  logic          rtcRise;
  logic          cmpRise;

  // a level counts only once stages two and three agree
  always_comb begin
    rtcRise        = (rtcSync[1] == rtcSync[2]) && rtcSync[2] && !rtcStable;
    cmpRise        = (cmpSync[1] == cmpSync[2]) && cmpSync[2] && !cmpStable;
    next_rtcStable = (rtcSync[1] == rtcSync[2]) ? rtcSync[2] : rtcStable;
    next_cmpStable = (cmpSync[1] == cmpSync[2]) ? cmpSync[2] : cmpStable;
    next_sysCnt    = (sysCnt == SYS_LAST) ? '0 : sysCnt + SW'(1);
    next_rtcCnt    = rtcCnt;
    if (rtcRise) begin
      next_rtcCnt = (rtcCnt == RTC_LAST) ? '0 : rtcCnt + RW'(1);
    end
  end

  // registers; strobes are registered too
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rtcSync         <= 3'h0;
      cmpSync         <= 3'h0;
      rtcStable       <= 1'b0;
      cmpStable       <= 1'b0;
      sysCnt          <= '0;
      rtcCnt          <= '0;
      ticks.tickSys12 <= 1'b0;
      ticks.tickRtc8  <= 1'b0;
      ticks.tickCmp0  <= 1'b0;
    end else begin
      rtcSync         <= {rtcSync[1:0], rtcClk};
      cmpSync         <= {cmpSync[1:0], cmp0Out};
      rtcStable       <= next_rtcStable;
      cmpStable       <= next_cmpStable;
      sysCnt          <= next_sysCnt;
      rtcCnt          <= next_rtcCnt;
      ticks.tickSys12 <= (sysCnt == SYS_LAST);
      ticks.tickRtc8  <= rtcRise && (rtcCnt == RTC_LAST);
      ticks.tickCmp0  <= cmpRise;
    end
  end
endmodule // arct_tick_gen

//--- src/arct_timer.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "arct_params.svh"
module arct_timer (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // asynchronous clock pins
  input  wire logic        rtcClk,
  input  wire logic        cmp0Out,
  // interrupt
  output logic             irq
);

  // strobes from the prescaler
  arct_tick_if tickBus ();

  arct_tick_gen #(
    .SYS_DIV (`ARCT_SYS_DIV),
    .RTC_DIV (`ARCT_RTC_DIV)
  ) u_tick_gen (
    .sys_clk (sys_clk),
    .rst     (rst),
    .rtcClk  (rtcClk),
    .cmp0Out (cmp0Out),
    .ticks   (tickBus.src)
  );

  // timer state
  arct_pkg::arct_byte_t countLow;          // low half of the count
  arct_pkg::arct_byte_t countHigh;         // high half of the count
  arct_pkg::arct_byte_t reloadLow;         // low reload or capture
  arct_pkg::arct_byte_t reloadHigh;        // high reload or capture
  logic                 highOverflowFlag;  // sticky high overflow
  logic                 lowOverflowFlag;   // sticky low overflow
  logic                 lowOverflowIrqEn;  // low overflow may interrupt
  logic                 captureModeEn;     // capture mode on
  logic                 splitModeSel;      // two 8-bit timers
  logic                 runCtrl;           // run control
  arct_pkg::arct_ext_t  extClockSel;       // external clock select
  logic                 lowSysclkSel;      // low half on system clock
  logic                 highSysclkSel;     // high half on system clock
  logic                 timerIrqEn;        // timer interrupt enable

  // next values of the timer state
  arct_pkg::arct_byte_t next_countLow;
  arct_pkg::arct_byte_t next_countHigh;
  arct_pkg::arct_byte_t next_reloadLow;
  arct_pkg::arct_byte_t next_reloadHigh;
  logic                 next_highOverflowFlag;
  logic                 next_lowOverflowFlag;
  logic                 next_lowOverflowIrqEn;
  logic                 next_captureModeEn;
  logic                 next_splitModeSel;
  logic                 next_runCtrl;
  arct_pkg::arct_ext_t  next_extClockSel;
  logic                 next_lowSysclkSel;
  logic                 next_highSysclkSel;
  logic                 next_timerIrqEn;
  logic                 next_irq;

  // bus next values
  logic                 next_pready;
  logic [31:0]          next_prdata;
  logic                 next_pslverr;

  // decoded strobes
  logic                 wrEn;              // write takes effect now
  logic                 lowTick;           // low half count strobe
  logic                 highTick;          // high half count strobe
  logic                 captureEvt;        // capture strobe
  logic [7:0]           wrByte;            // low byte of write data

  function automatic logic pickTick(
    input logic                sysSel,
    input arct_pkg::arct_ext_t ext,
    input logic                t12,
    input logic                tRtc,
    input logic                tCmp
  );
    logic t;
    t = 1'b0;
    if (sysSel) begin
      t = 1'b1;
    end else begin
      unique case (ext)
        arct_pkg::ARCT_EXT_SYS12: t = t12;
        arct_pkg::ARCT_EXT_RTC8:  t = tRtc;
        arct_pkg::ARCT_EXT_RSVD:  t = 1'b0;
        arct_pkg::ARCT_EXT_CMP0:  t = tCmp;
      endcase
    end
    return t;
  endfunction

  // address decode used by the error path only; the read path has its own case
  function automatic logic isMapped(input logic [11:0] a);
    return (a == `ARCT_OFF_CTRL)   || (a == `ARCT_OFF_RLD_LO) ||
           (a == `ARCT_OFF_RLD_HI) || (a == `ARCT_OFF_CNT_LO) ||
           (a == `ARCT_OFF_CNT_HI) || (a == `ARCT_OFF_CLKSEL) ||
           (a == `ARCT_OFF_MASK)   || (a == `ARCT_OFF_STATUS);
  endfunction

  // timer control as software sees it
  function automatic logic [7:0] ctrlView(
    input logic h, input logic l, input logic len, input logic cen,
    input logic sp, input logic run, input logic [1:0] ext
  );
    return {h, l, len, cen, sp, run, ext};
  endfunction

  // strobes for both halves and for capture
  always_comb begin
    wrEn       = psel && penable && pready && pwrite;
    wrByte     = pwdata[7:0];
    lowTick    = pickTick(lowSysclkSel, extClockSel, tickBus.tickSys12,
                          tickBus.tickRtc8, tickBus.tickCmp0);
    highTick   = pickTick(highSysclkSel, extClockSel, tickBus.tickSys12,
                          tickBus.tickRtc8, tickBus.tickCmp0);
    // capture source from select bit 1
    captureEvt = captureModeEn && (extClockSel[1] ? tickBus.tickCmp0
                                                  : tickBus.tickRtc8);
  end

  // next timer state: software first, hardware events after it
  always_comb begin
    next_countLow         = countLow;
    next_countHigh        = countHigh;
    next_reloadLow        = reloadLow;
    next_reloadHigh       = reloadHigh;
    next_highOverflowFlag = highOverflowFlag;
    next_lowOverflowFlag  = lowOverflowFlag;
    next_lowOverflowIrqEn = lowOverflowIrqEn;
    next_captureModeEn    = captureModeEn;
    next_splitModeSel     = splitModeSel;
    next_runCtrl          = runCtrl;
    next_extClockSel      = extClockSel;
    next_lowSysclkSel     = lowSysclkSel;
    next_highSysclkSel    = highSysclkSel;
    next_timerIrqEn       = timerIrqEn;
    next_irq              = 1'b0;

    // software writes; flags can only be cleared, through status
    if (wrEn) begin
      unique case (paddr)
        `ARCT_OFF_CTRL: begin
          next_lowOverflowIrqEn = wrByte[`ARCT_CTRL_LEN];
          next_captureModeEn    = wrByte[`ARCT_CTRL_CEN];
          next_splitModeSel     = wrByte[`ARCT_CTRL_SPLIT];
          next_runCtrl          = wrByte[`ARCT_CTRL_RUN];
          next_extClockSel      = arct_pkg::arct_ext_t'(wrByte[1:0]);
        end
        `ARCT_OFF_RLD_LO: next_reloadLow  = wrByte;
        `ARCT_OFF_RLD_HI: next_reloadHigh = wrByte;
        `ARCT_OFF_CNT_LO: next_countLow   = wrByte;
        `ARCT_OFF_CNT_HI: next_countHigh  = wrByte;
        `ARCT_OFF_CLKSEL: begin
          next_lowSysclkSel  = wrByte[`ARCT_CLK_LSYS];
          next_highSysclkSel = wrByte[`ARCT_CLK_HSYS];
        end
        `ARCT_OFF_MASK: begin
          // bit 1 is the same storage as the control low enable
          next_timerIrqEn       = wrByte[`ARCT_ST_HIGH];
          next_lowOverflowIrqEn = wrByte[`ARCT_ST_LOW];
        end
        `ARCT_OFF_STATUS: begin
          if (wrByte[`ARCT_ST_HIGH]) begin
            next_highOverflowFlag = 1'b0;
          end
          if (wrByte[`ARCT_ST_LOW]) begin
            next_lowOverflowFlag = 1'b0;
          end
        end
        default: begin
          // unmapped: nothing stored
        end
      endcase
    end

    // mode chosen by the split bit
    if (splitModeSel) begin
      if (lowTick) begin
        if (countLow == 8'hff) begin
          // low reloads from its own value
          next_countLow        = reloadLow;
          next_lowOverflowFlag = 1'b1;
        end else begin
          next_countLow = countLow + 8'h01;
        end
      end
      if (runCtrl && highTick) begin
        if (countHigh == 8'hff) begin
          // high reloads from its own value
          next_countHigh        = reloadHigh;
          next_highOverflowFlag = 1'b1;
        end else begin
          next_countHigh = countHigh + 8'h01;
        end
      end
    end else if (runCtrl && lowTick) begin
      if ({countHigh, countLow} == 16'hffff) begin
        next_countLow         = reloadLow;
        next_countHigh        = reloadHigh;
        next_highOverflowFlag = 1'b1;
        next_lowOverflowFlag  = 1'b1;
      end else if (countLow == 8'hff) begin
        // low byte wrap sets low flag
        next_countLow         = 8'h00;
        next_countHigh        = countHigh + 8'h01;
        next_lowOverflowFlag  = 1'b1;
      end else begin
        next_countLow = countLow + 8'h01;
      end
    end

    // capture copies the count; it beats a reload write
    if (captureEvt) begin
      next_reloadLow        = countLow;
      next_reloadHigh       = countHigh;
      next_highOverflowFlag = 1'b1;
    end

    // low flag joins when low enable set
    next_irq = next_timerIrqEn && (next_highOverflowFlag ||
               (next_lowOverflowIrqEn && next_lowOverflowFlag));
  end

  // apb: one wait cycle so read data comes from a flip-flop
  always_comb begin
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !isMapped(paddr);
    next_prdata  = 32'h0000_0000;
    if (next_pready && !pwrite) begin
      unique case (paddr)
        `ARCT_OFF_CTRL:   next_prdata[7:0] = ctrlView(highOverflowFlag,
                              lowOverflowFlag, lowOverflowIrqEn, captureModeEn,
                              splitModeSel, runCtrl, extClockSel);
        `ARCT_OFF_RLD_LO: next_prdata[7:0] = reloadLow;
        `ARCT_OFF_RLD_HI: next_prdata[7:0] = reloadHigh;
        `ARCT_OFF_CNT_LO: next_prdata[7:0] = countLow;
        `ARCT_OFF_CNT_HI: next_prdata[7:0] = countHigh;
        `ARCT_OFF_CLKSEL: next_prdata[1:0] = {highSysclkSel, lowSysclkSel};
        `ARCT_OFF_MASK:   next_prdata[1:0] = {lowOverflowIrqEn, timerIrqEn};
        `ARCT_OFF_STATUS: next_prdata[1:0] = {lowOverflowFlag, highOverflowFlag};
        default:          next_prdata      = 32'h0000_0000;
      endcase
    end
  end

  // register everything; reset leaves the timer stopped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      countLow         <= `ARCT_RST_BYTE;
      countHigh        <= `ARCT_RST_BYTE;
      reloadLow        <= `ARCT_RST_BYTE;
      reloadHigh       <= `ARCT_RST_BYTE;
      highOverflowFlag <= 1'b0;
      lowOverflowFlag  <= 1'b0;
      lowOverflowIrqEn <= 1'b0;
      captureModeEn    <= 1'b0;
      splitModeSel     <= 1'b0;
      runCtrl          <= 1'b0;
      extClockSel      <= arct_pkg::ARCT_EXT_SYS12;
      lowSysclkSel     <= 1'b0;
      highSysclkSel    <= 1'b0;
      timerIrqEn       <= 1'b0;
      irq              <= 1'b0;
      pready           <= 1'b0;
      prdata           <= 32'h0000_0000;
      pslverr          <= 1'b0;
    end else begin
      countLow         <= next_countLow;
      countHigh        <= next_countHigh;
      reloadLow        <= next_reloadLow;
      reloadHigh       <= next_reloadHigh;
      highOverflowFlag <= next_highOverflowFlag;
      lowOverflowFlag  <= next_lowOverflowFlag;
      lowOverflowIrqEn <= next_lowOverflowIrqEn;
      captureModeEn    <= next_captureModeEn;
      splitModeSel     <= next_splitModeSel;
      runCtrl          <= next_runCtrl;
      extClockSel      <= next_extClockSel;
      lowSysclkSel     <= next_lowSysclkSel;
      highSysclkSel    <= next_highSysclkSel;
      timerIrqEn       <= next_timerIrqEn;
      irq              <= next_irq;
      pready           <= next_pready;
      prdata           <= next_prdata;
      pslverr          <= next_pslverr;
    end
  end
endmodule // arct_timer

//--- verification/arct_timer_chk.sv
`timescale 1ns/1ns
`include "arct_params.svh"
// port-level checks on the timer: apb timing and interrupt causes
module arct_timer_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // interrupt
  input wire logic        irq
);
  logic maskEn;       // shadow of the timer irq enable
  logic next_maskEn;  // its next value
  logic badAddr;      // unaligned or past the last register
  logic irqWr;        // landed write that may lower irq
  assign badAddr = (paddr[1:0] != 2'h0) || (paddr > `ARCT_OFF_STATUS);
  assign irqWr = pready && pwrite && (paddr == `ARCT_OFF_STATUS ||
                 paddr == `ARCT_OFF_MASK || paddr == `ARCT_OFF_CTRL);
  // shadow follows mask writes at the edge they land
  always_comb begin
    next_maskEn = maskEn;
    if (pready && pwrite && paddr == `ARCT_OFF_MASK) begin
      next_maskEn = pwdata[0];
    end
  end
  // register the shadow
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      maskEn <= 1'b0;
    end else begin
      maskEn <= next_maskEn;
    end
  end
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_latency_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not in second access cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  err_decode_a: assert property (pready |-> pslverr == badAddr)
    else $error("error flag disagrees with address map");
  err_only_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without pready");
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(irqWr))
    else $error("irq dropped without software write");
  irq_masked_a: assert property (!maskEn |-> !irq)
    else $error("irq high while disabled");
  irq_rise_cause_a: assert property ($rose(irq) |-> maskEn)
    else $error("irq rose while disabled");
  // main scenarios reached
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule // arct_timer_chk

bind arct_timer arct_timer_chk chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .irq(irq));

//--- verification/arct_timer_test.sv
`timescale 1ns/1ns
`include "arct_params.svh"
module arct_timer_test;
  // clock and reset
  logic        sys_clk;
  logic        rst;
  // apb master
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  // slow pins and interrupt
  logic        rtcClk;
  logic        cmp0Out;
  logic        irq;
  // bench state
  int          numErrors;  // mismatches
  int          nTests;     // comparisons
  int          rtcCnt;     // rtc half period
  int          cmpCnt;     // comparator half period
  logic [31:0] rdv;        // last read data
  logic        rde;        // last error flag
  int          rLo;        // random reload low
  int          rHi;        // random reload high
  int          cnt;        // assembled count
  int          v[$];       // captured values
  // model: clock select, ext code, expected count over 484 cycles, slack
  int          tab[5][4] = '{'{0, 0, 40, 2}, '{0, 1, 6, 1}, '{0, 2, 0, 0},
                             '{0, 3, 12, 1}, '{1, 2, 484, 2}};

  arct_timer dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rtcClk(rtcClk), .cmp0Out(cmp0Out), .irq(irq));

  // 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // rtc period 10 cycles, comparator 40: both slow enough for the synchroniser
  always @(posedge sys_clk) begin
    rtcCnt <= (rtcCnt == 4) ? 0 : rtcCnt + 1;
    cmpCnt <= (cmpCnt == 19) ? 0 : cmpCnt + 1;
    if (rtcCnt == 4) begin
      rtcClk <= ~rtcClk;
    end
    if (cmpCnt == 19) begin
      cmp0Out <= ~cmp0Out;
    end
  end

  // verdict and stop
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; pready and data taken at the rising edge, released after it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) begin
        break;
      end
    end
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      numErrors++;
      endSim();
    end
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  // poll a status bit, bounded
  task automatic waitFlag(input int b);
    int n;
    for (n = 0; n < 100; n++) begin
      rd(`ARCT_OFF_STATUS);
      if (rdv[b] === 1'b1) begin
        break;
      end
    end
    if (n == 100) begin
      numErrors++;
      endSim();
    end
  endtask

  // irq looked at away from the edge
  task automatic irqIs(input logic e);
    @(negedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, e});
    @(posedge sys_clk);
  endtask

  initial begin
    {psel, penable, pwrite, rtcClk, cmp0Out} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {rtcCnt, cmpCnt, numErrors, nTests} = '0;
    rst = 1'b1;
    void'($urandom(32'hc8129ac3));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // every register clear after reset, then an unmapped read refused
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4));
      check("reset value", rdv, 32'h0);
    end
    rd(12'h020);
    check("unmapped error", {31'h0, rde}, 32'h1);
    rLo = $urandom_range(127);
    rHi = $urandom_range(255);
    wr(`ARCT_OFF_RLD_LO, 8'(rLo));
    wr(`ARCT_OFF_RLD_HI, 8'(rHi));
    wr(`ARCT_OFF_CNT_LO, 8'hfa);
    wr(`ARCT_OFF_CNT_HI, 8'hff);
    wr(`ARCT_OFF_CLKSEL, 8'h01);
    wr(`ARCT_OFF_MASK, 8'h01);
    rd(`ARCT_OFF_CNT_LO);
    check("held count", rdv, 32'hfa);
    wr(`ARCT_OFF_CTRL, 8'h04);
    waitFlag(`ARCT_ST_HIGH);
    wr(`ARCT_OFF_CTRL, 8'h00);
    irqIs(1'b1);
    rd(`ARCT_OFF_CNT_HI);
    check("reload high", rdv, 32'(rHi));
    repeat (20) @(posedge sys_clk);
    rd(`ARCT_OFF_STATUS);
    check("flags kept", rdv, 32'h3);
    wr(`ARCT_OFF_STATUS, 8'h01);
    irqIs(1'b0);
    rd(`ARCT_OFF_STATUS);
    check("low flag left", rdv, 32'h2);
    // low byte wrap interrupt and carry
    wr(`ARCT_OFF_CNT_LO, 8'hf8);
    wr(`ARCT_OFF_CNT_HI, 8'h00);
    wr(`ARCT_OFF_STATUS, 8'h02);
    wr(`ARCT_OFF_CTRL, 8'h24);
    waitFlag(`ARCT_ST_LOW);
    wr(`ARCT_OFF_CTRL, 8'h20);
    irqIs(1'b1);
    rd(`ARCT_OFF_STATUS);
    check("low only", rdv, 32'h2);
    rd(`ARCT_OFF_CNT_HI);
    check("carry", rdv, 32'h1);
    wr(`ARCT_OFF_STATUS, 8'h02);
    irqIs(1'b0);
    rLo = $urandom_range(127);
    rHi = $urandom_range(127);
    wr(`ARCT_OFF_RLD_LO, 8'(rLo));
    wr(`ARCT_OFF_RLD_HI, 8'(rHi));
    wr(`ARCT_OFF_CNT_LO, 8'hf0);
    wr(`ARCT_OFF_CNT_HI, 8'hf0);
    wr(`ARCT_OFF_CLKSEL, 8'h03);
    wr(`ARCT_OFF_CTRL, 8'h08);
    waitFlag(`ARCT_ST_LOW);
    irqIs(1'b0);
    rd(`ARCT_OFF_CNT_HI);
    check("high held", rdv, 32'hf0);
    rd(`ARCT_OFF_CNT_LO);
    check("low reload", {31'h0, rdv >= rLo && rdv < rLo + 64}, 32'h1);
    wr(`ARCT_OFF_CTRL, 8'h0c);
    waitFlag(`ARCT_ST_HIGH);
    wr(`ARCT_OFF_CTRL, 8'h08);
    irqIs(1'b1);
    rd(`ARCT_OFF_CNT_HI);
    check("high reload", {31'h0, rdv >= rHi && rdv < rHi + 64}, 32'h1);
    wr(`ARCT_OFF_STATUS, 8'h03);
    wr(`ARCT_OFF_CTRL, 8'h00);
    // every clock source, reserved code holds still
    for (int k = 0; k < 5; k++) begin
      wr(`ARCT_OFF_CLKSEL, 8'(tab[k][0]));
      wr(`ARCT_OFF_CNT_LO, 8'h00);
      wr(`ARCT_OFF_CNT_HI, 8'h00);
      wr(`ARCT_OFF_CTRL, 8'(4 + tab[k][1]));
      repeat (480) @(posedge sys_clk);
      wr(`ARCT_OFF_CTRL, 8'h00);
      rd(`ARCT_OFF_CNT_LO);
      cnt = int'(rdv);
      rd(`ARCT_OFF_CNT_HI);
      cnt += int'(rdv) * 256;
      check("source count", {31'h0, cnt >= tab[k][2] - tab[k][3] &&
            cnt <= tab[k][2] + tab[k][3]}, 32'h1);
    end
    wr(`ARCT_OFF_CLKSEL, 8'h01);
    for (int s = 0; s < 2; s++) begin
      // fast count clock, two captures subtracted
      wr(`ARCT_OFF_CTRL, 8'(8'h14 + 2 * s));
      waitFlag(`ARCT_ST_HIGH);
      irqIs(1'b1);
      for (int j = 0; j < 2; j++) begin
        wr(`ARCT_OFF_STATUS, 8'h01);
        waitFlag(`ARCT_ST_HIGH);
        rd(`ARCT_OFF_RLD_LO);
        cnt = int'(rdv);
        rd(`ARCT_OFF_RLD_HI);
        v.push_back(cnt + int'(rdv) * 256);
      end
      check("capture period", 32'((v[1] - v[0]) & 16'hffff), 32'(s ? 40 : 80));
      v.delete();
      wr(`ARCT_OFF_CTRL, 8'h00);
    end
    endSim();
  end
endmodule // arct_timer_test
